// ==== ptr_cmd_map.vh ====
`ifndef PTR_CMD_MAP_VH
`define PTR_CMD_MAP_VH

// Header dword fields
`define HDR_TYPE_HI 31
`define HDR_TYPE_LO 29
`define HDR_SUBTYPE_HI 28
`define HDR_SUBTYPE_LO 27
`define HDR_OPCODE_HI 26
`define HDR_OPCODE_LO 24
`define HDR_SUBOP_HI 23
`define HDR_SUBOP_LO 16
`define HDR_RSVD_HI 15
`define HDR_RSVD_LO 8
`define HDR_LEN_HI 7
`define HDR_LEN_LO 0

// Header field values
`define GRAPHICS_PIPE_CMD_TYPE 3'h3
`define THREE_D_CMD_SUBTYPE 2'h3
`define PIPELINED_STATE_OPCODE 3'h0
`define LENGTH_FIELD_TWO_DW 8'h00

// Sub-opcodes
`define SUBOP_BLEND 8'h24
`define SUBOP_DEPTH_STENCIL 8'h25
`define SUBOP_BT_VERTEX 8'h26
`define SUBOP_BT_HULL 8'h27
`define SUBOP_BT_DOMAIN 8'h28
`define SUBOP_BT_GEOMETRY 8'h29

// Dynamic state pointer fields
`define DYN_PTR_HI 31
`define DYN_PTR_LO 6
`define DYN_PAD_HI 5
`define DYN_PAD_LO 0

// Binding table pointer fields
`define BT_PAD_HI_HI 31
`define BT_PAD_HI_LO 16
`define BT_PTR_HI 15
`define BT_PTR_LO 5
`define BT_PAD_LO_HI 4
`define BT_PAD_LO_LO 0

// Target selector indices
`define TGT_BLEND 0
`define TGT_DEPTH 1
`define TGT_VERTEX 2
`define TGT_HULL 3
`define TGT_DOMAIN 4
`define TGT_GEOMETRY 5
`define TGT_COUNT 6

// Register indices on the software port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_BLEND 4'h2
`define REG_DEPTH 4'h3
`define REG_VERTEX 4'h4
`define REG_HULL 4'h5
`define REG_DOMAIN 4'h6
`define REG_GEOM 4'h7
`define REG_COUNT 4'h8

// Control reset values: stream on, lenient body check
`define CTRL_ENABLE_RST 1'b1
`define CTRL_STRICT_RST 1'b0

`endif

// ==== ptr_hold.v ====
`timescale 1ns/1ps
`default_nettype none

// One latched state pointer, loaded only when its own target is written
module ptr_hold #(
	parameter WIDTH = 26
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Load
	input wire load,
	input wire [WIDTH-1:0] load_value,
	// Held value
	output reg [WIDTH-1:0] ptr_reg
);

	// Value stays until the next load of this target
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_reg <= {WIDTH{1'b0}};
		end else if (load) begin
			ptr_reg <= load_value;
		end
	end

endmodule
`default_nettype wire

// ==== header_match.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ptr_cmd_map.vh"

// Combinational check of a header dword against the pipelined state group
module header_match (
	// Header dword
	input wire [31:0] header,
	// Results
	output wire group_ok,
	output wire form_ok,
	output wire [7:0] sub_opcode
);

	// Group match: type, subtype and opcode together
	assign group_ok =
		(header[`HDR_TYPE_HI:`HDR_TYPE_LO] == `GRAPHICS_PIPE_CMD_TYPE) &&
		(header[`HDR_SUBTYPE_HI:`HDR_SUBTYPE_LO] == `THREE_D_CMD_SUBTYPE) &&
		(header[`HDR_OPCODE_HI:`HDR_OPCODE_LO] == `PIPELINED_STATE_OPCODE);

	// Two-dword length and zero reserved byte
	assign form_ok =
		(header[`HDR_LEN_HI:`HDR_LEN_LO] == `LENGTH_FIELD_TWO_DW) &&
		(header[`HDR_RSVD_HI:`HDR_RSVD_LO] == 8'h00);

	assign sub_opcode = header[`HDR_SUBOP_HI:`HDR_SUBOP_LO];

endmodule
`default_nettype wire

// ==== state_pointer_command_decoder.v ====
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ptr_cmd_map.vh"

module state_pointer_command_decoder #(
	parameter DYN_W = 26,
	parameter BT_W = 11
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Command dword stream from the command streamer
	input wire dw_valid,
	input wire [31:0] dw_data,
	output reg dw_ready,
	// Latched pointers to the fixed-function units
	output reg [DYN_W-1:0] blend_ptr,
	output reg [DYN_W-1:0] depth_stencil_ptr,
	output reg [BT_W-1:0] vertex_stage_bt_ptr,
	output reg [BT_W-1:0] hull_stage_bt_ptr,
	output reg [BT_W-1:0] domain_stage_bt_ptr,
	output reg [BT_W-1:0] geometry_stage_bt_ptr,
	// Event pulses
	output reg ptr_update,
	output reg [`TGT_COUNT-1:0] ptr_update_sel,
	output reg cmd_error,
	output reg cmd_skip,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata
);

	// Register indices
	localparam [3:0] A_CTRL = `REG_CTRL;
	localparam [3:0] A_STATUS = `REG_STATUS;
	localparam [3:0] A_BLEND = `REG_BLEND;
	localparam [3:0] A_DEPTH = `REG_DEPTH;
	localparam [3:0] A_VERTEX = `REG_VERTEX;
	localparam [3:0] A_HULL = `REG_HULL;
	localparam [3:0] A_DOMAIN = `REG_DOMAIN;
	localparam [3:0] A_GEOM = `REG_GEOM;
	localparam [3:0] A_COUNT = `REG_COUNT;

	// Decoder states
	localparam [2:0] S_HEADER = 3'b001;
	localparam [2:0] S_BODY = 3'b010;
	localparam [2:0] S_SKIP = 3'b100;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`TGT_COUNT-1:0] target_reg;
	reg [`TGT_COUNT-1:0] target_next;
	reg [7:0] skip_cnt_reg;
	reg [7:0] skip_cnt_next;
	reg enable_reg;
	reg strict_reg;
	reg err_sticky_reg;
	reg [15:0] cmd_cnt_reg;
	reg [`TGT_COUNT-1:0] load_sel;
	reg load_ok;
	reg err_now;
	reg skip_now;

	wire group_ok;
	wire form_ok;
	wire [7:0] sub_opcode;
	wire [DYN_W-1:0] blend_q;
	wire [DYN_W-1:0] depth_q;
	wire [BT_W-1:0] vertex_q;
	wire [BT_W-1:0] hull_q;
	wire [BT_W-1:0] domain_q;
	wire [BT_W-1:0] geom_q;
	wire [DYN_W-1:0] dyn_field;
	wire [BT_W-1:0] bt_field;
	wire dyn_pad_ok;
	wire bt_pad_ok;
	wire take;
	wire is_dyn_target;

	header_match u_match (
		.header(dw_data),
		.group_ok(group_ok),
		.form_ok(form_ok),
		.sub_opcode(sub_opcode)
	);

	////////////////////////////////////////////////////////////////////////
	// Body dword fields
	assign take = dw_valid && dw_ready;
	assign dyn_field = dw_data[`DYN_PTR_HI:`DYN_PTR_LO];
	assign dyn_pad_ok = (dw_data[`DYN_PAD_HI:`DYN_PAD_LO] == 6'h00);
	assign bt_field = dw_data[`BT_PTR_HI:`BT_PTR_LO];
	assign bt_pad_ok = (dw_data[`BT_PAD_HI_HI:`BT_PAD_HI_LO] == 16'h0000) &&
		(dw_data[`BT_PAD_LO_HI:`BT_PAD_LO_LO] == 5'h00);
	assign is_dyn_target = target_reg[`TGT_BLEND] || target_reg[`TGT_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Command state machine
	always @* begin
		state_next = state_reg;
		target_next = target_reg;
		skip_cnt_next = skip_cnt_reg;
		load_sel = {`TGT_COUNT{1'b0}};
		load_ok = 1'b0;
		err_now = 1'b0;
		skip_now = 1'b0;
		case (state_reg)
			S_HEADER: begin
				if (take) begin
					target_next = {`TGT_COUNT{1'b0}};
					// Sub-opcode selects at most one target
					if (sub_opcode == `SUBOP_BLEND) begin
						target_next[`TGT_BLEND] = 1'b1;
					end else if (sub_opcode == `SUBOP_DEPTH_STENCIL) begin
						target_next[`TGT_DEPTH] = 1'b1;
					end else if (sub_opcode == `SUBOP_BT_VERTEX) begin
						target_next[`TGT_VERTEX] = 1'b1;
					end else if (sub_opcode == `SUBOP_BT_HULL) begin
						target_next[`TGT_HULL] = 1'b1;
					end else if (sub_opcode == `SUBOP_BT_DOMAIN) begin
						target_next[`TGT_DOMAIN] = 1'b1;
					end else if (sub_opcode == `SUBOP_BT_GEOMETRY) begin
						target_next[`TGT_GEOMETRY] = 1'b1;
					end
					if (group_ok && form_ok && (target_next != 0)) begin
						state_next = S_BODY;
					end else begin
						// Foreign or malformed command: pass over its body by its length
						skip_now = 1'b1;
						err_now = group_ok && (target_next != 0);
						target_next = {`TGT_COUNT{1'b0}};
						skip_cnt_next = dw_data[`HDR_LEN_HI:`HDR_LEN_LO] + 8'h01;
						state_next = S_SKIP;
					end
				end
			end
			S_BODY: begin
				if (take) begin
					state_next = S_HEADER;
					// Strict mode refuses a body with nonzero reserved bits
					if (is_dyn_target ? (dyn_pad_ok || !strict_reg) :
						(bt_pad_ok || !strict_reg)) begin
						load_sel = target_reg;
						load_ok = 1'b1;
					end else begin
						err_now = 1'b1;
					end
				end
			end
			S_SKIP: begin
				if (take) begin
					skip_cnt_next = skip_cnt_reg - 8'h01;
					if (skip_cnt_reg == 8'h01) begin
						state_next = S_HEADER;
					end
				end
			end
			default: begin
				state_next = S_HEADER;
			end
		endcase
	end

	// State registers
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_HEADER;
			target_reg <= {`TGT_COUNT{1'b0}};
			skip_cnt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			target_reg <= target_next;
			skip_cnt_reg <= skip_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One holder per target, so one command never disturbs another stage
	ptr_hold #(.WIDTH(DYN_W)) u_blend (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_BLEND]), .load_value(dyn_field),
		.ptr_reg(blend_q)
	);
	ptr_hold #(.WIDTH(DYN_W)) u_depth (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_DEPTH]), .load_value(dyn_field),
		.ptr_reg(depth_q)
	);
	ptr_hold #(.WIDTH(BT_W)) u_vertex (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_VERTEX]), .load_value(bt_field),
		.ptr_reg(vertex_q)
	);
	ptr_hold #(.WIDTH(BT_W)) u_hull (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_HULL]), .load_value(bt_field),
		.ptr_reg(hull_q)
	);
	ptr_hold #(.WIDTH(BT_W)) u_domain (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_DOMAIN]), .load_value(bt_field),
		.ptr_reg(domain_q)
	);
	ptr_hold #(.WIDTH(BT_W)) u_geom (
		.core_clk(core_clk), .rst_b(rst_b),
		.load(load_sel[`TGT_GEOMETRY]), .load_value(bt_field),
		.ptr_reg(geom_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs come from flops; pointers mirror holders one cycle later
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			blend_ptr <= {DYN_W{1'b0}};
			depth_stencil_ptr <= {DYN_W{1'b0}};
			vertex_stage_bt_ptr <= {BT_W{1'b0}};
			hull_stage_bt_ptr <= {BT_W{1'b0}};
			domain_stage_bt_ptr <= {BT_W{1'b0}};
			geometry_stage_bt_ptr <= {BT_W{1'b0}};
			ptr_update <= 1'b0;
			ptr_update_sel <= {`TGT_COUNT{1'b0}};
			cmd_error <= 1'b0;
			cmd_skip <= 1'b0;
			dw_ready <= 1'b0;
		end else begin
			blend_ptr <= blend_q;
			depth_stencil_ptr <= depth_q;
			vertex_stage_bt_ptr <= vertex_q;
			hull_stage_bt_ptr <= hull_q;
			domain_stage_bt_ptr <= domain_q;
			geometry_stage_bt_ptr <= geom_q;
			ptr_update <= load_ok;
			ptr_update_sel <= load_sel;
			cmd_error <= err_now;
			cmd_skip <= skip_now;
			dw_ready <= enable_reg; // Software can hold off the stream
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, sticky error and command count
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_reg <= `CTRL_ENABLE_RST;
			strict_reg <= `CTRL_STRICT_RST;
			err_sticky_reg <= 1'b0;
			cmd_cnt_reg <= 16'h0000;
		end else begin
			if (reg_wr && (reg_addr == A_CTRL)) begin
				enable_reg <= reg_wdata[0];
				strict_reg <= reg_wdata[1];
			end
			// Set wins over a clear in the same cycle
			if (err_now) begin
				err_sticky_reg <= 1'b1;
			end else if (reg_wr && (reg_addr == A_STATUS) && reg_wdata[0]) begin
				err_sticky_reg <= 1'b0;
			end
			if (load_ok) begin
				cmd_cnt_reg <= cmd_cnt_reg + 16'h0001;
			end
		end
	end

	// Read data valid the cycle after the read strobe only
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_addr == A_CTRL) begin
			reg_rdata <= {30'h0, strict_reg, enable_reg};
		end else if (reg_addr == A_STATUS) begin
			reg_rdata <= {28'h0, state_reg, err_sticky_reg};
		end else if (reg_addr == A_BLEND) begin
			reg_rdata <= {blend_q, 6'h00};
		end else if (reg_addr == A_DEPTH) begin
			reg_rdata <= {depth_q, 6'h00};
		end else if (reg_addr == A_VERTEX) begin
			reg_rdata <= {16'h0, vertex_q, 5'h00};
		end else if (reg_addr == A_HULL) begin
			reg_rdata <= {16'h0, hull_q, 5'h00};
		end else if (reg_addr == A_DOMAIN) begin
			reg_rdata <= {16'h0, domain_q, 5'h00};
		end else if (reg_addr == A_GEOM) begin
			reg_rdata <= {16'h0, geom_q, 5'h00};
		end else if (reg_addr == A_COUNT) begin
			reg_rdata <= {16'h0, cmd_cnt_reg};
		end else begin
			reg_rdata <= 32'h00000000; // Unmapped reads zero
		end
	end

endmodule
`default_nettype wire

// ==== ptr_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Ties every pointer load to the two dwords that caused it
module ptr_monitor #(
	parameter DYN_W = 26,
	parameter BT_W = 11
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Command stream
	input wire dw_valid,
	input wire [31:0] dw_data,
	input wire dw_ready,
	// Pointers and pulses
	input wire [DYN_W-1:0] blend_ptr,
	input wire [DYN_W-1:0] depth_stencil_ptr,
	input wire [BT_W-1:0] vertex_stage_bt_ptr,
	input wire [BT_W-1:0] hull_stage_bt_ptr,
	input wire [BT_W-1:0] domain_stage_bt_ptr,
	input wire [BT_W-1:0] geometry_stage_bt_ptr,
	input wire ptr_update,
	input wire [5:0] ptr_update_sel
);
	reg [31:0] body_q;
	reg [31:0] hdr_q;
	// Last two accepted dwords, header then body
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			body_q <= 32'h0;
			hdr_q <= 32'h0;
		end else if (dw_valid && dw_ready) begin
			body_q <= dw_data;
			hdr_q <= body_q;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_HDR_GROUP: assert property (
		ptr_update |-> hdr_q[31:24] == 8'h78) else $error("bad group");
	AST_HDR_LEN: assert property (
		ptr_update |-> hdr_q[15:0] == 16'h0) else $error("bad length");
	AST_SEL_MAP: assert property (
		ptr_update |-> ptr_update_sel == 6'h01 << (hdr_q[23:16] - 8'h24))
		else $error("wrong target");
	AST_SEL_QUIET: assert property (
		!ptr_update |-> ptr_update_sel == 6'h0) else $error("stray select");
	AST_BLEND_VAL: assert property (
		ptr_update && ptr_update_sel[0] |=> blend_ptr == $past(body_q[31:6]))
		else $error("blend value");
	AST_DEPTH_VAL: assert property (
		ptr_update && ptr_update_sel[1] |=>
		depth_stencil_ptr == $past(body_q[31:6])) else $error("depth value");
	AST_VERTEX_VAL: assert property (
		ptr_update && ptr_update_sel[2] |=>
		vertex_stage_bt_ptr == $past(body_q[15:5])) else $error("vertex value");
	AST_HULL_VAL: assert property (
		ptr_update && ptr_update_sel[3] |=>
		hull_stage_bt_ptr == $past(body_q[15:5])) else $error("hull value");
	AST_DOMAIN_VAL: assert property (
		ptr_update && ptr_update_sel[4] |=>
		domain_stage_bt_ptr == $past(body_q[15:5])) else $error("domain value");
	AST_GEOM_VAL: assert property (
		ptr_update && ptr_update_sel[5] |=>
		geometry_stage_bt_ptr == $past(body_q[15:5])) else $error("geom value");
endmodule
bind state_pointer_command_decoder ptr_monitor #(.DYN_W(DYN_W), .BT_W(BT_W))
	mon (.core_clk(core_clk), .rst_b(rst_b), .dw_valid(dw_valid),
	.dw_data(dw_data), .dw_ready(dw_ready), .blend_ptr(blend_ptr),
	.depth_stencil_ptr(depth_stencil_ptr),
	.vertex_stage_bt_ptr(vertex_stage_bt_ptr),
	.hull_stage_bt_ptr(hull_stage_bt_ptr),
	.domain_stage_bt_ptr(domain_stage_bt_ptr),
	.geometry_stage_bt_ptr(geometry_stage_bt_ptr),
	.ptr_update(ptr_update), .ptr_update_sel(ptr_update_sel));
`default_nettype wire

// ==== cmd_streamer.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Ring fetch model: offers queued dwords, holds each until taken
module cmd_streamer (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Flow
	input wire stall,
	input wire dw_ready,
	output logic dw_valid,
	output logic [31:0] dw_data
);
	logic [31:0] q[$];
	// Pop on acceptance; idle data toggles so nothing stale looks valid
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dw_valid <= 1'b0;
			dw_data <= 32'h0;
		end else begin
			if (dw_valid && dw_ready)
				void'(q.pop_front());
			if (dw_valid && !dw_ready) begin
				dw_valid <= 1'b1;
			end else if (q.size() != 0 && !stall) begin
				dw_valid <= 1'b1;
				dw_data <= q[0];
			end else begin
				dw_valid <= 1'b0;
				dw_data <= ~dw_data;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module tb;
	logic core_clk = 0, rst_b = 0, stall = 0, dw_valid, dw_ready;
	logic [31:0] dw_data, reg_wdata = 0, reg_rdata, lf = 32'hab4d, rd;
	logic [3:0] reg_addr = 0;
	logic reg_wr = 0, reg_rd = 0, ptr_update, cmd_error, cmd_skip;
	logic [25:0] bl, dp;
	logic [10:0] vx, hl, dm, gm;
	logic [5:0] sel;
	int n_skip = 0, n_err = 0;
	logic [31:0] ex[6], keep;
	int err_count = 0, n_compared = 0, i;
	state_pointer_command_decoder DUT (.core_clk(core_clk), .rst_b(rst_b),
		.dw_valid(dw_valid), .dw_data(dw_data), .dw_ready(dw_ready),
		.blend_ptr(bl), .depth_stencil_ptr(dp), .vertex_stage_bt_ptr(vx),
		.hull_stage_bt_ptr(hl), .domain_stage_bt_ptr(dm),
		.geometry_stage_bt_ptr(gm), .ptr_update(ptr_update),
		.ptr_update_sel(sel), .cmd_error(cmd_error), .cmd_skip(cmd_skip),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	cmd_streamer cs (.core_clk(core_clk), .rst_b(rst_b), .stall(stall),
		.dw_ready(dw_ready), .dw_valid(dw_valid), .dw_data(dw_data));
	initial forever #50 core_clk = ~core_clk;
	// Next state of the stimulus shift register
	function automatic [31:0] lfsr_next(input [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Random stalls; pulse counters run on across all tests, never cleared
	always @(posedge core_clk) begin
		lf <= lfsr_next(lf);
		stall <= lf[3] & lf[7];
		if (cmd_skip) n_skip <= n_skip + 1;
		if (cmd_error) n_err <= n_err + 1;
	end
	////////////////////////////////////////////////////////////////////
	function automatic [31:0] hdr(input [7:0] sub, input [7:0] len);
		hdr = {3'h3, 2'h3, 3'h0, sub, 8'h00, len};
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task send(input [31:0] d);
		cs.q.push_back(d);
	endtask
	// Drain the stream, then let the mirrors settle
	task drain;
		for (int k = 0; k < 200 && (cs.q.size() != 0 || dw_valid); k++)
			@(posedge core_clk);
		repeat (4) @(posedge core_clk);
	endtask
	task ptrs;
		chk("blend", ex[0], {6'h0, bl});
		chk("depth", ex[1], {6'h0, dp});
		chk("vertex", ex[2], {21'h0, vx});
		chk("hull", ex[3], {21'h0, hl});
		chk("domain", ex[4], {21'h0, dm});
		chk("geom", ex[5], {21'h0, gm});
	endtask
	task reg_w(input [3:0] a, input [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task reg_r(input [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 rd = reg_rdata;
	endtask
	// One target load with a random aligned offset
	task load(input int t);
		logic [31:0] b;
		b = t < 2 ? lf & 32'hffffffc0 : lf & 32'h0000ffe0;
		ex[t] = t < 2 ? b[31:6] : b[15:5];
		send(hdr(8'h24 + t[7:0], 8'h00));
		send(b);
	endtask
	task wrap_up;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		for (i = 0; i < 6; i++) ex[i] = 0;
		repeat (5) @(posedge core_clk);
		rst_b <= 1;
		ptrs;
		for (i = 0; i < 18; i++) begin
			load(i % 6);
			@(posedge core_clk);
		end
		drain;
		ptrs;
		$display("test loads done");
		send(32'h58240001);
		send(32'hffffffff);
		send(32'hffffffff);
		send(hdr(8'h27, 8'h01));
		send(32'h0);
		send(32'h0);
		send(hdr(8'h2a, 8'h00));
		send(32'h0);
		load(3);
		drain;
		ptrs;
		chk("skip", 3, n_skip);
		chk("form error", 1, n_err);
		$display("test skips done");
		reg_w(4'h0, 32'h3);
		send(hdr(8'h24, 8'h00));
		send(32'h00000041);
		drain;
		ptrs;
		chk("error", 2, n_err);
		reg_r(4'h1);
		chk("sticky", 1, rd[0]);
		reg_w(4'h1, 32'h1);
		reg_r(4'h1);
		chk("cleared", 0, rd[0]);
		reg_w(4'h0, 32'h0);
		keep = ex[5];
		load(5);
		repeat (10) @(posedge core_clk);
		chk("paused", keep, {21'h0, gm});
		reg_w(4'h0, 32'h1);
		// Lenient mode keeps the offset and ignores the low bits
		send(hdr(8'h24, 8'h00));
		send(32'h00001241);
		ex[0] = 32'h49;
		drain;
		ptrs;
		$display("test strict done");
		reg_r(4'h2);
		chk("rd blend", {ex[0][25:0], 6'h0}, rd);
		reg_r(4'h5);
		chk("rd hull", {ex[3][26:0], 5'h0}, rd);
		reg_r(4'hf);
		chk("rd none", 0, rd);
		reg_r(4'h8);
		chk("loads", 21, rd);
		$display("test regs done");
		wrap_up;
	end
endmodule
`default_nettype wire
